// ### bench/sats_mem_model.sv
// Purpose: memory side that flags a dependent command sent too soon
// Assumes: need_i is the spacing the memory requires
// Notes: gap saturates so idle time never wraps
`timescale 1ns/100ps
`default_nettype none
module sats_mem_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic issue_i,
   input wire logic [7:0] need_i,
   output logic early_o
);
   logic [7:0] gap;
   // spacing since the reference command, checked when the dependent one lands
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap <= 8'hff;
         early_o <= 1'b0;
      end else begin
         if (start_i) gap <= 8'h00;
         else if (gap != 8'hff) gap <= gap + 8'h01;
         if (issue_i && gap < need_i) early_o <= 1'b1;
      end
   end
endmodule : sats_mem_model
`default_nettype wire

// ### bench/sats_timing_select_asserts.sv
// Purpose: port checks of the ac timing selector
// Assumes: config held steady while judged
// Notes: counts judged one cycle after their config
`timescale 1ns/100ps
`default_nettype none
module sats_timing_select_asserts (
   // clock, reset, config
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [1:0] freq_code_i,
   input wire logic mem_type_mobile_i,
   input wire logic [1:0] memory_operating_mode_i,
   input wire logic high_freq_sel_i,
   input wire logic ext_table_en_i,
   // timers and counts
   input wire logic [10:0] ref_start_i,
   input wire logic [87:0] ac_count_o,
   input wire logic [10:0] cmd_permit_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // last config {run, ext, hf, mobile, mode, freq}; run low keeps reset values out
   logic [7:0] pc;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) pc <= 8'h00;
      else pc <= {1'b1, ext_table_en_i, high_freq_sel_i, mem_type_mobile_i,
                  memory_operating_mode_i, freq_code_i};
   end
   property p_lmob; pc[7:6]==2'h2 && pc[4] && pc[1:0]==0 |-> ac_count_o[15:0]==16'h080c;
   endproperty
   a_lmob: assert property (p_lmob) else $error("legacy mobile count wrong");
   property p_lsdr; pc[7:6]==2'h2 && !pc[4] && pc[1:0]==0 |-> ac_count_o[7:0]==8'h09;
   endproperty
   a_lsdr: assert property (p_lsdr) else $error("legacy sdram count wrong");
   property p_lset; pc[7:6]==2'h2 && pc[4] && pc[1:0]==1 |-> ac_count_o[31:16]==16'h0402;
   endproperty
   a_lset: assert property (p_lset) else $error("mixed legacy set");
   property p_col; pc[7:5]==3'h6 && pc[1:0]==0 |-> ac_count_o[7:0]==(pc[3] ? 8'h0c : 8'h09);
   endproperty
   a_col: assert property (p_col) else $error("wrong column for mode");
   property p_wr; pc[7:5]==3'h6 |-> ac_count_o[55:48]==(pc[2] ? 8'h03 : 8'h02)
      && ac_count_o[71:64]==(pc[2] ? 8'h04 : 8'h01); endproperty
   a_wr: assert property (p_wr) else $error("wr or ccd wrong");
   property p_xs; pc[7:5]==3'h6 && pc[3:0]==4'h5 |-> ac_count_o[63:56]==8'hcd; endproperty
   a_xs: assert property (p_xs) else $error("exit count wrong");
   property p_hf; pc[7:5]==3'h7 && pc[3:2]==2'h1 |-> ac_count_o[79:56]==24'h0004c8;
   endproperty
   a_hf: assert property (p_hf) else $error("high freq set wrong");
   // a start with a count of 12 keeps the permit low for at least 8 edges
   property p_hold; ref_start_i[0] && ac_count_o[7:0]==8'h0c |=> !cmd_permit_o[0] [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("permit came early");
   c_hf: cover property (pc[7:5]==3'h7);
   c_leg: cover property (pc[7:6]==2'h2 && pc[4]);
   c_tmr: cover property (ref_start_i[0] ##1 !cmd_permit_o[0]);
endmodule : sats_timing_select_asserts
`default_nettype wire

// ### bench/sats_timing_select_tb_top.sv
// Purpose: bench for the ac timing selector
// Assumes: 25 MHz clock, inputs driven on rising edges
// Notes: expected counts typed in from the timing tables
`timescale 1ns/100ps
`default_nettype none
module sats_timing_select_tb_top;
   logic clk_i = 1'b0, rst_b_i = 1'b0, mob = 1'b0, hf = 1'b0, ext = 1'b0, issue = 1'b0, early;
   logic [1:0] freq = 2'h0, mode = 2'h0;
   logic [10:0] start = 11'h000, permit;
   logic [87:0] count;
   logic [7:0] need = 8'h00;
   int fails = 0, samples_checked = 0, cycles = 0;
   logic [7:0] lmob [5][4] = '{'{8'h0c, 8'h07, 8'h03, 8'h02}, '{8'h08, 8'h05, 8'h03, 8'h02},
      '{8'h04, 8'h02, 8'h02, 8'h02}, '{8'h05, 8'h04, 8'h02, 8'h02}, '{8'h03, 8'h02, 8'h02, 8'h02}};
   logic [23:0] hfc [4] = '{24'h010902, 24'h04d103, 24'h010c02, 24'h041503}; // ccd, exit, wr
   logic [7:0] x11 [4] = '{8'h1b, 8'h1b, 8'h0e, 8'h07};
   logic [7:0] x10 [4] = '{8'h0f, 8'h0c, 8'h08, 8'h04}; // exit, mode 10, high freq set
   logic [7:0] x00 [4] = '{8'h09, 8'h07, 8'h06, 8'h03}; // rc, mode 00, high freq set
   logic [7:0] rfc0 [4] = '{8'h09, 8'h0d, 8'h0c, 8'h10}; // rfc by mode, freq 0, clear
   always #20 clk_i = ~clk_i;
   sats_timing_select dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .freq_code_i(freq),
      .mem_type_mobile_i(mob), .memory_operating_mode_i(mode), .high_freq_sel_i(hf),
      .ext_table_en_i(ext), .ref_start_i(start), .ac_count_o(count), .cmd_permit_o(permit));
   sats_mem_model mem_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start[0]),
      .issue_i(issue), .need_i(need), .early_o(early));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   // apply a config, then let the registered counts settle
   task cfg(input logic e, h, m, input logic [1:0] md, f);
      @(posedge clk_i);
      {ext, hf, mob, mode, freq} <= {e, h, m, md, f};
      repeat (2) @(posedge clk_i);
      #1;
   endtask : cfg
   // start rc and cdl timers, time the rc hold-off, then send the dependent command
   task t_timer(input int n_exp, input logic p9_exp);
      int n;
      n = 0;
      need = n_exp[7:0];
      @(posedge clk_i);
      start <= 11'h201;
      @(posedge clk_i);
      start <= 11'h000;
      #1;
      check(permit[9], p9_exp);
      while (!permit[0] && n < 40) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check(n, n_exp);
      // issue in the very cycle the permit rises, the tightest legal spacing
      issue = 1'b1;
      @(posedge clk_i);
      issue <= 1'b0;
      #1;
      check(early, 1'b0);
   endtask : t_timer
   // hang guard: the run needs about 113 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // legacy mobile with mode and high-frequency bits set, which must not matter
      for (int f = 0; f < 4; f++) begin
         cfg(1'b0, 1'b1, 1'b1, 2'h1, f[1:0]);
         for (int p = 0; p < 5; p++)
            check(count[p*8 +: 8], lmob[p][f]);
      end
      cfg(1'b0, 1'b0, 1'b0, 2'h2, 2'h0);
      check(count[31:0], 32'h03030609);
      // extended tables pick by mode; memory type set against the column
      for (int m = 0; m < 4; m++) begin
         cfg(1'b1, 1'b0, !m[1], m[1:0], 2'h0);
         check(count[7:0], m[1] ? 8'h0c : 8'h09);
         check(count[71:48], hfc[m]);
         check({count[87:80], count[47:40]}, {8'h02, rfc0[m]});
      end
      cfg(1'b1, 1'b0, 1'b0, 2'h1, 2'h1);
      check(count[63:56], 8'hcd);
      for (int f = 0; f < 4; f++) begin
         cfg(1'b1, 1'b1, 1'b0, 2'h1, f[1:0]);
         check(count[79:56], 24'h0004c8);
         cfg(1'b1, 1'b1, 1'b1, 2'h3, f[1:0]);
         check(count[63:56], x11[f]);
         cfg(1'b1, 1'b1, 1'b0, 2'h2, f[1:0]);
         check(count[63:56], x10[f]);
         cfg(1'b1, 1'b1, 1'b1, 2'h0, f[1:0]);
         check(count[7:0], x00[f]);
      end
      cfg(1'b0, 1'b0, 1'b1, 2'h0, 2'h0);
      t_timer(12, 1'b0);
      cfg(1'b1, 1'b1, 1'b0, 2'h1, 2'h0);
      t_timer(9, 1'b1);
      conclude();
   end
endmodule : sats_timing_select_tb_top
bind sats_timing_select sats_timing_select_asserts chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .freq_code_i(freq_code_i), .mem_type_mobile_i(mem_type_mobile_i),
   .memory_operating_mode_i(memory_operating_mode_i), .high_freq_sel_i(high_freq_sel_i),
   .ext_table_en_i(ext_table_en_i), .ref_start_i(ref_start_i), .ac_count_o(ac_count_o),
   .cmd_permit_o(cmd_permit_o));
`default_nettype wire

// ### design/sats_pkg.sv
// Purpose : constants and timing tables for the ac timing selector
// Assumes : counts are in controller clock cycles, 8 bits wide
// Notes   : table index order is [high freq][op mode][parameter][freq code]
package sats_pkg;

   // ----------------------------------------------------------------
   // widths and parameter indices
   // ----------------------------------------------------------------
   localparam int CNT_W  = 8;
   localparam int NPARAM = 11;
   localparam int NLEGACY = 5;
   localparam int P_RC  = 0;
   localparam int P_RAS = 1;
   localparam int P_RCD = 2;
   localparam int P_RP  = 3;
   localparam int P_RRD = 4;
   localparam int P_RFC = 5;
   localparam int P_WR  = 6;
   localparam int P_XSR = 7;
   localparam int P_CCD = 8;
   localparam int P_CDL = 9;
   localparam int P_MRD = 10;
   localparam logic [1:0]       MODE_SDR_BASE = 2'h0;  // legacy fill-in column, sdram
   localparam logic [1:0]       MODE_MOB_BASE = 2'h2;  // legacy fill-in column, mobile
   localparam logic [CNT_W-1:0] CNT_SAT       = 8'hff; // timer idle / saturated value

   // ----------------------------------------------------------------
   // legacy tables: rc, ras, rcd, rp, rrd by freq code
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] LEG_SDR [NLEGACY][4] = '{
      '{8'h09, 8'h05, 8'h03, 8'h02}, '{8'h06, 8'h03, 8'h03, 8'h02},
      '{8'h03, 8'h02, 8'h02, 8'h02}, '{8'h03, 8'h02, 8'h02, 8'h02},
      '{8'h02, 8'h02, 8'h02, 8'h02}};
   localparam logic [CNT_W-1:0] LEG_MOB [NLEGACY][4] = '{
      '{8'h0c, 8'h07, 8'h03, 8'h02}, '{8'h08, 8'h05, 8'h03, 8'h02},
      '{8'h04, 8'h02, 8'h02, 8'h02}, '{8'h05, 8'h04, 8'h02, 8'h02},
      '{8'h03, 8'h02, 8'h02, 8'h02}};

   // ----------------------------------------------------------------
   // extended tables
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] EXT_TBL [2][4][NPARAM][4] = '{
      '{ // high frequency select cleared
         '{'{8'h09, 8'h05, 8'h03, 8'h03}, '{8'h06, 8'h03, 8'h03, 8'h02},
           '{8'h03, 8'h02, 8'h02, 8'h02}, '{8'h03, 8'h02, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h09, 8'h05, 8'h03, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h09, 8'h05, 8'h03, 8'h02},
           '{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h01, 8'h01, 8'h01, 8'h01},
           '{8'h02, 8'h02, 8'h02, 8'h02}},
         '{'{8'h09, 8'h05, 8'h03, 8'h03}, '{8'h06, 8'h03, 8'h03, 8'h02},
           '{8'h03, 8'h03, 8'h03, 8'h03}, '{8'h03, 8'h02, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h0d, 8'h05, 8'h03, 8'h02},
           '{8'h03, 8'h03, 8'h03, 8'h03}, '{8'hd1, 8'hcd, 8'hd1, 8'hd1},
           '{8'h04, 8'h04, 8'h04, 8'h04}, '{8'h02, 8'h02, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}},
         '{'{8'h0c, 8'h07, 8'h03, 8'h02}, '{8'h08, 8'h05, 8'h03, 8'h02},
           '{8'h04, 8'h02, 8'h02, 8'h02}, '{8'h05, 8'h04, 8'h02, 8'h02},
           '{8'h03, 8'h02, 8'h02, 8'h02}, '{8'h0c, 8'h07, 8'h03, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h0c, 8'h07, 8'h03, 8'h02},
           '{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h01, 8'h01, 8'h01, 8'h01},
           '{8'h02, 8'h02, 8'h02, 8'h02}},
         '{'{8'h0c, 8'h07, 8'h03, 8'h03}, '{8'h08, 8'h05, 8'h03, 8'h02},
           '{8'h04, 8'h03, 8'h03, 8'h03}, '{8'h05, 8'h04, 8'h02, 8'h02},
           '{8'h03, 8'h02, 8'h02, 8'h02}, '{8'h10, 8'h07, 8'h03, 8'h03},
           '{8'h03, 8'h03, 8'h03, 8'h03}, '{8'h15, 8'h0e, 8'h07, 8'h03},
           '{8'h04, 8'h04, 8'h04, 8'h04}, '{8'h02, 8'h02, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}}},
      '{ // high frequency select set
         '{'{8'h09, 8'h07, 8'h06, 8'h03}, '{8'h06, 8'h05, 8'h04, 8'h02},
           '{8'h03, 8'h02, 8'h02, 8'h02}, '{8'h03, 8'h02, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h09, 8'h07, 8'h06, 8'h03},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h09, 8'h07, 8'h06, 8'h03},
           '{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h01, 8'h01, 8'h01, 8'h01},
           '{8'h02, 8'h02, 8'h02, 8'h02}},
         '{'{8'h09, 8'h07, 8'h06, 8'h03}, '{8'h06, 8'h05, 8'h04, 8'h02},
           '{8'h03, 8'h03, 8'h03, 8'h03}, '{8'h03, 8'h02, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h0a, 8'h08, 8'h06, 8'h03},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'hc8, 8'hc8, 8'hc8, 8'hc8},
           '{8'h04, 8'h04, 8'h04, 8'h04}, '{8'h00, 8'h00, 8'h00, 8'h00},
           '{8'h02, 8'h02, 8'h02, 8'h02}},
         '{'{8'h0b, 8'h09, 8'h07, 8'h03}, '{8'h07, 8'h07, 8'h05, 8'h02},
           '{8'h04, 8'h03, 8'h02, 8'h02}, '{8'h04, 8'h03, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h0d, 8'h0a, 8'h07, 8'h04},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h0f, 8'h0c, 8'h08, 8'h04},
           '{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h01, 8'h01, 8'h01, 8'h01},
           '{8'h02, 8'h02, 8'h02, 8'h02}},
         '{'{8'h0b, 8'h09, 8'h07, 8'h03}, '{8'h07, 8'h07, 8'h05, 8'h02},
           '{8'h04, 8'h03, 8'h03, 8'h03}, '{8'h04, 8'h03, 8'h02, 8'h02},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h0d, 8'h0b, 8'h08, 8'h04},
           '{8'h02, 8'h02, 8'h02, 8'h02}, '{8'h1b, 8'h1b, 8'h0e, 8'h07},
           '{8'h04, 8'h04, 8'h04, 8'h04}, '{8'h00, 8'h00, 8'h00, 8'h00},
           '{8'h02, 8'h02, 8'h02, 8'h02}}}};

endpackage : sats_pkg

// ### design/sats_timing_select.sv
// Purpose : selects the memory ac timing counts and enforces them as hold-off timers
// Assumes : all configuration inputs come from logic on clk_i
// Notes   : selected counts are registered, so a config change takes effect one cycle later
// Functional notes
// (RL1) Mobile DDR legacy timing uses rc 12/7/3/2, ras 8/5/3/2, rp 5/4/2/2, rcd 4/2/2/2, rrd 3/2/2/2.
// (RL2) The memory-type setting alone chooses between the sdram and mobile legacy sets.
// (RL3) The frequency code decodes into exactly one set at a time, never a mix of two.
// (RL4) With the extended tables enabled the high-frequency bit, frequency code and mode pick the table.
// (RL5) Modes 00 and 01 pick sdram columns, 10 and 11 pick mobile columns, each with its own counts.
// (RL6) High-frequency bit clear: modes 01/11 use long self-refresh exit, wr 3 and ccd 4; 00/10 wr 2, ccd 1. Code: mode 11 exit is 21/14/7/3.
// (RL7) High-frequency bit set: mode 01 exit is 200, mode 11 is 27/27/14/7, and cdl is zero in both.
// (RL8) Each dependent command is held off until the selected count of cycles has passed since its reference.
`timescale 1ns/100ps
`default_nettype none

module sats_timing_select #(
   parameter int FREQ_W = 2,
   parameter int MODE_W = 2
) (
   // clock and reset
   input  wire logic                                       clk_i,
   input  wire logic                                       rst_b_i,
   // configuration
   input  wire logic [FREQ_W-1:0]                          freq_code_i,
   input  wire logic                                       mem_type_mobile_i,
   input  wire logic [MODE_W-1:0]                          memory_operating_mode_i,
   input  wire logic                                       high_freq_sel_i,
   input  wire logic                                       ext_table_en_i,
   // reference command strobes, one per parameter
   input  wire logic [sats_pkg::NPARAM-1:0]                ref_start_i,
   // selected counts and hold-off permits
   output logic      [sats_pkg::NPARAM*sats_pkg::CNT_W-1:0] ac_count_o,
   output logic      [sats_pkg::NPARAM-1:0]                cmd_permit_o
);

   // ----------------------------------------------------------------
   // table lookup
   // ----------------------------------------------------------------
   // table chosen per parameter, so legacy configs mix legacy set entries with base-column ones
   function automatic logic [sats_pkg::CNT_W-1:0] sats_lookup(
      input logic              ext,
      input logic              hf,
      input logic              mobile,
      input logic [1:0]        mode,
      input logic [FREQ_W-1:0] freq,
      input int                p
   );
      logic [sats_pkg::CNT_W-1:0] val;
      logic [1:0]                 base;
      val  = '0;
      base = mobile ? sats_pkg::MODE_MOB_BASE : sats_pkg::MODE_SDR_BASE; // RL2
      if (ext) begin
         val = sats_pkg::EXT_TBL[hf][mode][p][freq];                     // RL4 RL5 RL6 RL7
      end else if (p < sats_pkg::NLEGACY) begin
         if (mobile) begin
            val = sats_pkg::LEG_MOB[p][freq];                            // RL1 RL2 RL3
         end else begin
            val = sats_pkg::LEG_SDR[p][freq];                            // RL3
         end
      end else begin
         // legacy sets give no value here; fall back to the base column
         val = sats_pkg::EXT_TBL[1'b0][base][p][freq];
      end
      return val;
   endfunction : sats_lookup

   // ----------------------------------------------------------------
   // selected counts
   // ----------------------------------------------------------------
   logic [sats_pkg::CNT_W-1:0] sel_cnt      [sats_pkg::NPARAM];
   logic [sats_pkg::CNT_W-1:0] next_sel_cnt [sats_pkg::NPARAM];

   // compute every count from the current configuration
   always_comb begin
      for (int p = 0; p < sats_pkg::NPARAM; p++) begin
         next_sel_cnt[p] = sats_lookup(ext_table_en_i, high_freq_sel_i, mem_type_mobile_i,
                                       memory_operating_mode_i[1:0], freq_code_i, p);
      end
   end

   // registered so the long lookup path stays off the permit compare
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int p = 0; p < sats_pkg::NPARAM; p++) begin
            sel_cnt[p] <= sats_pkg::CNT_SAT;   // most cautious until first edge
         end
      end else begin
         for (int p = 0; p < sats_pkg::NPARAM; p++) begin
            sel_cnt[p] <= next_sel_cnt[p];
         end
      end
   end

   // ----------------------------------------------------------------
   // hold-off timers
   // ----------------------------------------------------------------
   logic [sats_pkg::CNT_W-1:0] elapsed      [sats_pkg::NPARAM];
   logic [sats_pkg::CNT_W-1:0] next_elapsed [sats_pkg::NPARAM];

   // restart on reference strobe, else count up and saturate
   always_comb begin
      for (int p = 0; p < sats_pkg::NPARAM; p++) begin
         if (ref_start_i[p]) begin
            next_elapsed[p] = '0;                                        // RL8
         end else if (elapsed[p] != sats_pkg::CNT_SAT) begin
            next_elapsed[p] = elapsed[p] + 8'h01;
         end else begin
            next_elapsed[p] = elapsed[p];
         end
      end
   end

   // timers start idle, so nothing is held off after reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int p = 0; p < sats_pkg::NPARAM; p++) begin
            elapsed[p] <= sats_pkg::CNT_SAT;
         end
      end else begin
         for (int p = 0; p < sats_pkg::NPARAM; p++) begin
            elapsed[p] <= next_elapsed[p];
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // permit is a handshake term, so it is left combinational
   always_comb begin
      for (int p = 0; p < sats_pkg::NPARAM; p++) begin
         cmd_permit_o[p] = (elapsed[p] >= sel_cnt[p]);                   // RL8
         ac_count_o[p*sats_pkg::CNT_W +: sats_pkg::CNT_W] = sel_cnt[p];
      end
   end

endmodule : sats_timing_select

`default_nettype wire
